/* File: bld_pkg.sv */
// Purpose: Shared constants for the boost LED configuration decoder.
// Assumes: 250 MHz core clock, I2C pins sampled as synchronous inputs.
// Notes:   Register map, reset values, field positions and decode tables.
package bld_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] REG_SWITCHING_CONTROL   = 8'h00;
  localparam logic [7:0] REG_FREQUENCY_AND_LIMIT = 8'h01;
  localparam logic [7:0] REG_LED_CURRENT_LEVEL   = 8'h02;

  // Writable bit masks; all other positions are restricted
  localparam logic [7:0] SWC_MASK = 8'hE0;
  localparam logic [7:0] FAL_MASK = 8'h1F;
  localparam logic [7:0] LCL_MASK = 8'hFF;

  localparam logic [7:0] SWC_RESET = 8'h60;
  localparam logic [7:0] FAL_RESET = 8'h17;
  localparam logic [7:0] LCL_RESET = 8'h82;

  // Field positions
  localparam int SPREAD_BIT   = 7;
  localparam int SLEW_MSB     = 6;
  localparam int SLEW_LSB     = 5;
  localparam int ILIM_BIT     = 4;
  localparam int FREQ_MSB     = 3;
  localparam int FREQ_LSB     = 0;

  // ==========================================================================
  // Decode tables
  // ==========================================================================
  localparam logic [7:0] SLEW_PCT_TAB [4] = '{8'h19, 8'h32, 8'h64, 8'hC8};

  localparam logic [11:0] ILIM_LOW_MA  = 12'h5DC;
  localparam logic [11:0] ILIM_HIGH_MA = 12'h9C4;

  localparam int FREQ_KHZ_TAB [16] = '{300, 300, 300, 300, 300, 400, 500, 600,
                                       700, 800, 900, 1000, 1225, 1335, 1450, 1600};

  localparam logic [7:0]  LED_LIN_BASE_CODE = 8'h30;
  localparam logic [15:0] LED_OFF_UA        = 16'h0000;
  localparam logic [15:0] LED_MIN_UA        = 16'h2738;
  localparam logic [15:0] LED_LIN_BASE_UA   = 16'h27B0;
  localparam logic [15:0] LED_STEP_UA       = 16'h0078;

  // Spread-spectrum period deviation in clock counts
  localparam int SPREAD_DEV = 16;

  // Default I2C slave address
  localparam logic [6:0] I2C_ADDR = 7'h3C;

endpackage

/* File: bld_switch_gate.sv */
// Purpose: Power-switch gate with cycle-by-cycle peak current limit.
// Assumes: Cycle start is a one-cycle pulse from the oscillator divider.
// Notes:   Over-limit beats cycle start so a hot switch never re-closes.
`timescale 1ns/10ps
`default_nettype none
module bld_switch_gate (
  input  wire logic        clk,          // Core clock
  input  wire logic        rst_b,        // Sync reset, active low
  input  wire logic        cycle_start,  // Oscillator cycle start pulse
  input  wire logic        duty_end,     // Loop ends on-time
  input  wire logic [11:0] peak_ma,      // Sensed inductor current
  input  wire logic [11:0] limit_ma,     // Selected current limit
  output logic             switch_on,    // Power switch gate
  output logic             ocp_event     // Limit trip pulse
);

  logic switch_on_r;
  logic switch_on_nxt;
  logic ocp_r;
  wire  over_limit = peak_ma > limit_ma;

  // ==========================================================================
  // Gate state
  // ==========================================================================
  always_comb begin
    if (over_limit) begin
      switch_on_nxt = 1'b0;
    end else if (cycle_start) begin
      switch_on_nxt = 1'b1;
    end else if (duty_end) begin
      switch_on_nxt = 1'b0;
    end else begin
      switch_on_nxt = switch_on_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      switch_on_r <= 1'b0;
      ocp_r       <= 1'b0;
    end else begin
      switch_on_r <= switch_on_nxt;
      ocp_r       <= over_limit & switch_on_r;
    end
  end

  assign switch_on = switch_on_r;
  assign ocp_event = ocp_r;

endmodule
`default_nettype wire

/* File: bld_i2c_slave.sv */
// Purpose: I2C register slave with pointer byte and auto-increment.
// Assumes: SCL and SDA already synchronous to clk and glitch free.
// Notes:   Clock stretching is not supported; every pointer is acked.
`timescale 1ns/10ps
`default_nettype none
module bld_i2c_slave #(
  parameter logic [6:0] ADDR = bld_pkg::I2C_ADDR
) (
  input  wire logic       clk,       // Core clock
  input  wire logic       rst_b,     // Sync reset, active low
  input  wire logic       scl_in,    // I2C clock level
  input  wire logic       sda_in,    // I2C data level
  output logic            sda_out,   // I2C data drive value
  output logic            sda_oe,    // I2C data drive enable
  output logic            wr_pulse,  // Register write strobe
  output logic [7:0]      wr_addr,   // Register write address
  output logic [7:0]      wr_data,   // Register write data
  output logic [7:0]      rd_addr,   // Register read address
  input  wire logic [7:0] rd_data    // Register read data
);

  typedef enum logic [2:0] {
    BLD_IDLE = 3'b000,
    BLD_ADDR = 3'b001,
    BLD_PTR  = 3'b011,
    BLD_WR   = 3'b010,
    BLD_RD   = 3'b110
  } bld_i2c_e;

  bld_i2c_e    st_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shf_r;
  logic [7:0]  ptr_r;
  logic [7:0]  tx_r;
  logic        ack_r;
  logic        oe_r;
  logic        wr_r;
  logic [7:0]  wa_r;
  logic [7:0]  wd_r;

  wire       scl_rise  = scl_in & ~scl_d_r;
  wire       scl_fall  = ~scl_in & scl_d_r;
  wire       start_det = scl_in & scl_d_r & sda_d_r & ~sda_in;
  wire       stop_det  = scl_in & scl_d_r & ~sda_d_r & sda_in;
  wire       ack_slot  = cnt_r == 4'h8;
  wire [7:0] byte_in   = {shf_r[6:0], sda_in};
  wire [2:0] tx_idx    = 3'(4'h7 - cnt_r);

  // ==========================================================================
  // Protocol engine
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r    <= BLD_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      cnt_r   <= 4'h0;
      shf_r   <= 8'h00;
      ptr_r   <= 8'h00;
      tx_r    <= 8'h00;
      ack_r   <= 1'b0;
      oe_r    <= 1'b0;
      wr_r    <= 1'b0;
      wa_r    <= 8'h00;
      wd_r    <= 8'h00;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
      wr_r    <= 1'b0;
      if (start_det) begin
        st_r  <= BLD_ADDR;
        cnt_r <= 4'h0;
        oe_r  <= 1'b0;
      end else if (stop_det) begin
        st_r <= BLD_IDLE;
        oe_r <= 1'b0;
      end else if (st_r != BLD_IDLE && scl_rise) begin
        if (ack_slot) begin
          cnt_r <= 4'h0;
          unique case (st_r)
            BLD_ADDR: st_r <= !ack_r ? BLD_IDLE : (shf_r[0] ? BLD_RD : BLD_PTR);
            BLD_PTR:  st_r <= BLD_WR;
            BLD_WR:   st_r <= BLD_WR;
            BLD_RD: begin
              ptr_r <= ptr_r + 8'h01;
              if (sda_in) begin
                st_r <= BLD_IDLE;
              end
            end
            default:  st_r <= BLD_IDLE;
          endcase
        end else begin
          shf_r <= byte_in;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h7) begin
            unique case (st_r)
              BLD_ADDR: ack_r <= byte_in[7:1] == ADDR;
              BLD_PTR: begin
                ack_r <= 1'b1;
                ptr_r <= byte_in;
              end
              BLD_WR: begin
                ack_r <= 1'b1;
                wr_r  <= 1'b1;
                wa_r  <= ptr_r;
                wd_r  <= byte_in;
                ptr_r <= ptr_r + 8'h01;
              end
              BLD_RD:  ack_r <= 1'b0;
              default: ack_r <= 1'b0;
            endcase
          end
        end
      end else if (scl_fall) begin
        if (ack_slot) begin
          oe_r <= ack_r;
        end else if (st_r == BLD_RD && cnt_r == 4'h0) begin
          tx_r <= rd_data;
          oe_r <= ~rd_data[7];
        end else if (st_r == BLD_RD) begin
          oe_r <= ~tx_r[tx_idx];
        end else begin
          oe_r <= 1'b0;
        end
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe   = oe_r;
  assign wr_pulse = wr_r;
  assign wr_addr  = wa_r;
  assign wr_data  = wd_r;
  assign rd_addr  = ptr_r;

endmodule
`default_nettype wire

/* File: bld_config_decoder.sv */
// Purpose: Boost LED driver configuration registers and decode.
// Assumes: Host writes over I2C; peak current sensed as mA code.
// Notes:   Decoded outputs are registered, one edge after the write; period_cnt follows at the next cycle start.
`timescale 1ns/10ps
`default_nettype none
module bld_config_decoder #(
  parameter logic [6:0] I2C_ADDR   = bld_pkg::I2C_ADDR,
  parameter int         SPREAD_DEV = bld_pkg::SPREAD_DEV
) (
  input  wire logic        clk,                 // Core clock, 250 MHz
  input  wire logic        rst_b,               // Sync reset, active low
  input  wire logic        scl_in,              // I2C clock
  input  wire logic        sda_in,              // I2C data in
  output logic             sda_out,             // I2C data out value
  output logic             sda_oe,              // I2C data drive enable
  input  wire logic [11:0] peak_ma,             // Sensed peak current
  input  wire logic        duty_end,            // Loop on-time end
  output logic             switch_on,           // Power switch gate
  output logic             ocp_event,           // Current-limit trip
  output logic             cycle_start,         // Oscillator cycle start
  output logic [10:0]      freq_khz,            // Switching frequency
  output logic [9:0]       period_cnt,          // Cycle length in clocks
  output logic             spread_en,           // Spreading enabled
  output logic [1:0]       switch_node_slew,    // Edge-rate code
  output logic [7:0]       slew_pct,            // Edge-rate percent
  output logic [11:0]      ilim_ma,             // Current limit, mA
  output logic             ilim_high,           // 2.5A limit selected
  output logic [15:0]      channel_current_ua   // LED current, uA
);

  // ==========================================================================
  // Register bank
  // ==========================================================================
  logic [7:0] swc_r;
  logic [7:0] fal_r;
  logic [7:0] lcl_r;
  logic       wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  bld_i2c_slave #(
    .ADDR     (I2C_ADDR)
  ) u_i2c (
    .clk      (clk),
    .rst_b    (rst_b),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  wire sel_swc = wr_pulse && wr_addr == bld_pkg::REG_SWITCHING_CONTROL;
  wire sel_fal = wr_pulse && wr_addr == bld_pkg::REG_FREQUENCY_AND_LIMIT;
  wire sel_lcl = wr_pulse && wr_addr == bld_pkg::REG_LED_CURRENT_LEVEL;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      swc_r <= bld_pkg::SWC_RESET;
      fal_r <= bld_pkg::FAL_RESET;
      lcl_r <= bld_pkg::LCL_RESET;
    end else begin
      if (sel_swc) begin
        swc_r <= wr_data & bld_pkg::SWC_MASK;
      end
      if (sel_fal) begin
        fal_r <= wr_data & bld_pkg::FAL_MASK;
      end
      if (sel_lcl) begin
        lcl_r <= wr_data & bld_pkg::LCL_MASK;
      end
    end
  end

  // Unmapped pointers read as zero and ignore writes
  assign rd_data = (rd_addr == bld_pkg::REG_SWITCHING_CONTROL)   ? swc_r :
                   (rd_addr == bld_pkg::REG_FREQUENCY_AND_LIMIT) ? fal_r :
                   (rd_addr == bld_pkg::REG_LED_CURRENT_LEVEL)   ? lcl_r : 8'h00;

  // ==========================================================================
  // Field decode
  // ==========================================================================
  wire [1:0] slew_code = swc_r[bld_pkg::SLEW_MSB:bld_pkg::SLEW_LSB];
  wire       spread_b  = swc_r[bld_pkg::SPREAD_BIT];
  wire [3:0] freq_code = fal_r[bld_pkg::FREQ_MSB:bld_pkg::FREQ_LSB];
  wire       ilim_b    = fal_r[bld_pkg::ILIM_BIT];

  // Constant tables, folded at elaboration
  logic [10:0] khz_rom [16];
  logic [9:0]  per_rom [16];
  for (genvar gi = 0; gi < 16; gi++) begin : g_freq
    assign khz_rom[gi] = 11'(bld_pkg::FREQ_KHZ_TAB[gi]);
    assign per_rom[gi] = 10'(bld_pkg::CLK_KHZ / bld_pkg::FREQ_KHZ_TAB[gi]);
  end

  wire [7:0]  slew_pct_d = bld_pkg::SLEW_PCT_TAB[slew_code];
  wire [11:0] ilim_d     = ilim_b ? bld_pkg::ILIM_HIGH_MA
                                  : bld_pkg::ILIM_LOW_MA;

  // LED current: off, flat minimum, then linear steps
  wire [7:0]  led_ofs  = lcl_r - bld_pkg::LED_LIN_BASE_CODE;
  wire [15:0] led_lin  = bld_pkg::LED_LIN_BASE_UA
                         + 16'(led_ofs) * bld_pkg::LED_STEP_UA;
  wire        led_zero = lcl_r == 8'h00;
  wire        led_flat = lcl_r < bld_pkg::LED_LIN_BASE_CODE;
  wire [15:0] led_ua_d = led_zero ? bld_pkg::LED_OFF_UA :
                         led_flat ? bld_pkg::LED_MIN_UA : led_lin;

  // ==========================================================================
  // Registered decoded outputs
  // ==========================================================================
  logic [10:0] freq_khz_r;
  logic [9:0]  base_per_r;
  logic        spread_r;
  logic [1:0]  slew_r;
  logic [7:0]  slew_pct_r;
  logic [11:0] ilim_r;
  logic        ilim_high_r;
  logic [15:0] led_ua_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freq_khz_r  <= 11'h000;
      base_per_r  <= 10'h000;
      spread_r    <= 1'b0;
      slew_r      <= 2'h0;
      slew_pct_r  <= 8'h00;
      ilim_r      <= 12'h000;
      ilim_high_r <= 1'b0;
      led_ua_r    <= 16'h0000;
    end else begin
      freq_khz_r  <= khz_rom[freq_code];
      base_per_r  <= per_rom[freq_code];
      spread_r    <= spread_b;
      slew_r      <= slew_code;
      slew_pct_r  <= slew_pct_d;
      ilim_r      <= ilim_d;
      ilim_high_r <= ilim_b;
      led_ua_r    <= led_ua_d;
    end
  end

  // ==========================================================================
  // Oscillator with triangular spreading
  // ==========================================================================
  // Period is rebuilt at each cycle start so a new code never truncates
  // a cycle mid-way; the cost is up to one old-rate cycle of latency.
  localparam logic [9:0] DEV = 10'(SPREAD_DEV);
  localparam int RST_KHZ =
    bld_pkg::FREQ_KHZ_TAB[bld_pkg::FAL_RESET[bld_pkg::FREQ_MSB:bld_pkg::FREQ_LSB]];
  localparam logic [9:0] RST_PER = 10'(bld_pkg::CLK_KHZ / RST_KHZ);

  logic [9:0] osc_cnt_r;
  logic [9:0] cur_per_r;
  logic [9:0] dev_r;
  logic       dev_up_r;
  logic       cyc_r;

  wire        osc_wrap  = osc_cnt_r >= cur_per_r - 10'h001;
  wire [9:0]  spread_per = base_per_r - DEV + dev_r;
  wire [9:0]  next_per  = spread_r ? spread_per : base_per_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_cnt_r <= 10'h000;
      cur_per_r <= RST_PER;
      dev_r     <= 10'h000;
      dev_up_r  <= 1'b1;
      cyc_r     <= 1'b0;
    end else begin
      cyc_r <= osc_wrap;
      if (osc_wrap) begin
        osc_cnt_r <= 10'h000;
        cur_per_r <= next_per;
        if (!spread_r) begin
          dev_r    <= DEV;
          dev_up_r <= 1'b1;
        end else if (dev_up_r) begin
          dev_r    <= dev_r + 10'h001;
          dev_up_r <= ~(dev_r + 10'h001 >= (DEV << 1));
        end else begin
          dev_r    <= dev_r - 10'h001;
          dev_up_r <= dev_r == 10'h001;
        end
      end else begin
        osc_cnt_r <= osc_cnt_r + 10'h001;
      end
    end
  end

  // ==========================================================================
  // Power switch
  // ==========================================================================
  bld_switch_gate u_gate (
    .clk         (clk),
    .rst_b       (rst_b),
    .cycle_start (cyc_r),
    .duty_end    (duty_end),
    .peak_ma     (peak_ma),
    .limit_ma    (ilim_r),
    .switch_on   (switch_on),
    .ocp_event   (ocp_event)
  );

  assign cycle_start        = cyc_r;
  assign freq_khz           = freq_khz_r;
  assign period_cnt         = cur_per_r;
  assign spread_en          = spread_r;
  assign switch_node_slew   = slew_r;
  assign slew_pct           = slew_pct_r;
  assign ilim_ma            = ilim_r;
  assign ilim_high          = ilim_high_r;
  assign channel_current_ua = led_ua_r;

endmodule
`default_nettype wire

/* File: bld_cfg_props.sv */
// Purpose: Port assertions for the configuration decoder.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Value checks wait two edges after reset so outputs have settled; switch checks do not.
`timescale 1ns/10ps
`default_nettype none
module bld_cfg_props (
  input wire logic        clk,                // Core clock
  input wire logic        rst_b,              // Sync reset
  input wire logic        scl_in,             // I2C clock
  input wire logic        sda_in,             // I2C data in
  input wire logic        sda_out,            // I2C data value
  input wire logic        sda_oe,             // I2C data enable
  input wire logic [11:0] peak_ma,            // Peak current
  input wire logic        duty_end,           // On-time end
  input wire logic        switch_on,          // Switch gate
  input wire logic        ocp_event,          // Limit trip
  input wire logic        cycle_start,        // Cycle start
  input wire logic [10:0] freq_khz,           // Frequency
  input wire logic [9:0]  period_cnt,         // Cycle length
  input wire logic        spread_en,          // Spreading
  input wire logic [1:0]  switch_node_slew,   // Edge-rate code
  input wire logic [7:0]  slew_pct,           // Edge-rate percent
  input wire logic [11:0] ilim_ma,            // Current limit
  input wire logic        ilim_high,          // High limit
  input wire logic [15:0] channel_current_ua  // LED current
);
  // ==========
  // Helpers
  // ==========
  logic live1_r;
  logic live2_r;
  logic live;
  logic over;
  // Outputs other than period_cnt read zero in reset, so skip the release edges
  always_ff @(posedge clk) begin
    live1_r <= rst_b;
    live2_r <= rst_b & live1_r;
  end
  assign live = live2_r & rst_b;
  assign over = peak_ma > ilim_ma;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Assertions
  // ==========
  chk_slew_pct_map: assert property (live |->
    slew_pct == (8'h19 << switch_node_slew)) else $error("slew percent wrong");
  chk_freq_range: assert property (live |->
    freq_khz >= 11'h12C && freq_khz <= 11'h640) else $error("frequency out of range");
  chk_ilim_select: assert property (live |->
    ilim_ma == (ilim_high ? 12'h9C4 : 12'h5DC)) else $error("limit wrong");
  chk_current_low: assert property (live && channel_current_ua < 16'h27B0 |->
    channel_current_ua inside {16'h0000, 16'h2738}) else $error("low current wrong");
  chk_current_step: assert property (live && channel_current_ua >= 16'h27B0 |->
    channel_current_ua <= 16'h88B8 && (channel_current_ua - 16'h27B0) % 16'h0078 == 16'h0000)
    else $error("current step wrong");
  chk_switch_trip: assert property (switch_on && over |=>
    !switch_on && ocp_event) else $error("switch not cut");
  chk_switch_stays_off: assert property (!switch_on && !cycle_start |=>
    !switch_on) else $error("switch closed early");
  chk_switch_close: assert property (cycle_start && !over |=>
    switch_on) else $error("switch not closed");
  chk_reset_values: assert property ($rose(live2_r) |->
    freq_khz == 11'h258 && !spread_en && switch_node_slew == 2'h3 && ilim_high
    && channel_current_ua == 16'h4E20) else $error("reset values wrong");
  // Five high samples mean no bit can have landed recently
  chk_quiet_stable: assert property (live && scl_in && $past(scl_in) && $past(scl_in, 2)
    && $past(scl_in, 3) && $past(scl_in, 4) |-> $stable(spread_en) && $stable(ilim_high)
    && $stable(switch_node_slew) && $stable(channel_current_ua)) else $error("output moved");
  cov_trip: cover property (ocp_event);
  cov_spread: cover property (cycle_start && spread_en);
  cov_freq: cover property (live && $changed(freq_khz));
endmodule
bind bld_config_decoder bld_cfg_props u_bld_cfg_props (
  .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .peak_ma(peak_ma), .duty_end(duty_end), .switch_on(switch_on),
  .ocp_event(ocp_event), .cycle_start(cycle_start), .freq_khz(freq_khz),
  .period_cnt(period_cnt), .spread_en(spread_en), .switch_node_slew(switch_node_slew),
  .slew_pct(slew_pct), .ilim_ma(ilim_ma), .ilim_high(ilim_high),
  .channel_current_ua(channel_current_ua));
`default_nettype wire

/* File: bld_host_model.sv */
// Purpose: I2C host reaching the decoder registers.
// Assumes: Open-drain SDA; pull-up resolved by the bench.
// Notes:   SCL phases of four clocks, above the three-clock minimum.
`timescale 1ns/10ps
`default_nettype none
module bld_host_model #(
  parameter logic [6:0] ADDR = bld_pkg::I2C_ADDR
) (
  input  wire logic clk,       // Core clock
  input  wire logic sda_line,  // Resolved SDA
  output var  logic scl,       // SCL level
  output var  logic sda        // Host SDA, 1 releases
);
  // SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put(input logic b);
    sda <= b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic get(output logic b);
    sda <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    b = sda_line;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    tick(1);
    sda <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda <= 1'b1;
    tick(3);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = !a;
  endtask
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({ADDR, 1'b0}, a0);
    send(ptr, a1);
    send(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    send({ADDR, 1'b0}, a0);
    send(ptr, a1);
    start();
    send({ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench for the configuration decoder.
// Assumes: Host model drives I2C; bench drives the current sense.
// Notes:   Expected values come from local tables only.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, rst_b, scl, sda_h, sda_in, sda_out, sda_oe, duty_end;
  logic        switch_on, ocp_event, cycle_start, spread_en, ilim_high;
  logic [11:0] peak_ma, ilim_ma;
  logic [10:0] freq_khz;
  logic [9:0]  period_cnt;
  logic [1:0]  switch_node_slew;
  logic [7:0]  slew_pct;
  logic [15:0] channel_current_ua;
  int          num_errors, num_checks;
  assign sda_in = sda_h & ~sda_oe;
  bld_config_decoder u_bld_config_decoder (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .peak_ma(peak_ma), .duty_end(duty_end), .switch_on(switch_on),
    .ocp_event(ocp_event), .cycle_start(cycle_start), .freq_khz(freq_khz),
    .period_cnt(period_cnt), .spread_en(spread_en), .switch_node_slew(switch_node_slew),
    .slew_pct(slew_pct), .ilim_ma(ilim_ma), .ilim_high(ilim_high),
    .channel_current_ua(channel_current_ua));
  bld_host_model u_bld_host_model (.clk(clk), .sda_line(sda_in), .scl(scl), .sda(sda_h));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // Helpers
  // ==========
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ok;
    u_bld_host_model.write_reg(ptr, d, ok);
    check("write ack", 16'h0001, 16'(ok));
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_bld_host_model.read_reg(ptr, d, ok);
    check("read ack", 16'h0001, 16'(ok));
    check("read data", 16'(exp), 16'(d));
  endtask
  task automatic wait_cs();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 1200) begin
        num_errors++;
        $display("mismatch cycle_start expected 1 seen timeout");
        final_report();
      end
    end while (cycle_start !== 1'b1);
  endtask
  function automatic logic [15:0] exp_freq(input logic [3:0] c);
    if (c < 4'h5) return 16'h012C;
    if (c < 4'hC) return 16'h012C + 16'h0064 * (16'(c) - 16'h0004);
    case (c)
      4'hC: return 16'h04C9;
      4'hD: return 16'h0537;
      4'hE: return 16'h05AA;
      default: return 16'h0640;
    endcase
  endfunction
  function automatic logic [15:0] exp_ua(input logic [7:0] c);
    if (c == 8'h00) return 16'h0000;
    if (c < 8'h30) return 16'h2738;
    return 16'h27B0 + 16'h0078 * (16'(c) - 16'h0030);
  endfunction
  // ==========
  // Scenarios
  // ==========
  task automatic t_reset();
    check("freq", 16'h0258, 16'(freq_khz));
    check("period", 16'h01A0, 16'(period_cnt));
    check("slew", 16'h0003, 16'(switch_node_slew));
    check("spread", 16'h0000, 16'(spread_en));
    check("ilim", 16'h09C4, 16'(ilim_ma));
    check("current", 16'h4E20, channel_current_ua);
    check("sda out", 16'h0000, 16'(sda_out));
    rd(8'h00, 8'h60);
    rd(8'h01, 8'h17);
    rd(8'h02, 8'h82);
    $display("test reset done");
  endtask
  task automatic t_restricted();
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hE0);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h1F);
    wr(8'h05, 8'hAA);
    rd(8'h05, 8'h00);
    $display("test restricted done");
  endtask
  task automatic t_freq();
    for (int i = 0; i < 16; i++) begin
      wr(8'h01, {3'h0, 1'(i), 4'(i)});
      check("freq", exp_freq(4'(i)), 16'(freq_khz));
      check("ilim", i % 2 ? 16'h09C4 : 16'h05DC, 16'(ilim_ma));
      check("ilim high", 16'(i % 2), 16'(ilim_high));
    end
    $display("test frequency done");
  endtask
  task automatic t_slew();
    logic [7:0] pct [4];
    pct = '{8'h19, 8'h32, 8'h64, 8'hC8};
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, {1'(s), 2'(s), 5'h00});
      check("slew pct", 16'(pct[s]), 16'(slew_pct));
      check("spread", 16'(s % 2), 16'(spread_en));
    end
    $display("test slew done");
  endtask
  task automatic t_current();
    logic [7:0] codes [8];
    codes = '{8'h00, 8'h01, 8'h2F, 8'h30, 8'h31, 8'h82, 8'hFE, 8'hFF};
    for (int i = 0; i < 8; i++) begin
      wr(8'h02, codes[i]);
      check("current", exp_ua(codes[i]), channel_current_ua);
    end
    $display("test current done");
  endtask
  task automatic t_switch();
    wr(8'h01, 8'h07);
    wait_cs();
    #1 check("on", 16'h0001, 16'(switch_on));
    @(posedge clk) peak_ma <= 12'h5DC;
    // Equal to the limit must not trip
    @(posedge clk) peak_ma <= 12'h5DD;
    #1 check("on at limit", 16'h0001, 16'(switch_on));
    @(posedge clk) peak_ma <= 12'h000;
    #1 check("tripped", 16'h0000, 16'(switch_on));
    check("trip event", 16'h0001, 16'(ocp_event));
    repeat (8) @(posedge clk);
    #1 check("held off", 16'h0000, 16'(switch_on));
    wait_cs();
    #1 check("reclosed", 16'h0001, 16'(switch_on));
    @(posedge clk) duty_end <= 1'b1;
    @(posedge clk) duty_end <= 1'b0;
    #1 check("duty off", 16'h0000, 16'(switch_on));
    $display("test switch done");
  endtask
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    peak_ma = 12'h000;
    duty_end = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_restricted();
    t_freq();
    t_slew();
    t_current();
    t_switch();
    final_report();
  end
endmodule
`default_nettype wire
